// File: pmd_pkg.sv
package pmd_pkg;

  // Clocking: the microphone clock is derived from sys_clk
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int PDM_CLK_PERIOD_NS = 400;
  localparam int PDM_HALF_CYCLES = PDM_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam int PH_W = $clog2(2 * PDM_HALF_CYCLES);
  localparam int SYNC_STAGES = 2;
  // Pin value just before each clock edge reaches the synchroniser output
  localparam int RISE_TAP = SYNC_STAGES - 1;
  localparam int FALL_TAP = PDM_HALF_CYCLES + SYNC_STAGES - 1;

  // Data widths
  localparam int PCM_W = 16;
  localparam int CIC_W = 20;
  localparam int SUM_W = CIC_W + 6;
  localparam int DC_W = CIC_W + 10;
  localparam int RATIO_W = 7;
  localparam int MIN_RATIO = 2;
  localparam int MAX_RATIO = 64;

  // Half-band taps (-1 0 9 16 9 0 -1) / 32
  localparam logic signed [SUM_W-1:0] HB_C_OUTER = -26'sd1;
  localparam logic signed [SUM_W-1:0] HB_C_INNER = 26'sd9;
  localparam logic signed [SUM_W-1:0] HB_C_MID = 26'sd16;
  localparam int HB_SHIFT = 5;
  // Droop compensating FIR taps (-1 9 9 -1) / 16
  localparam logic signed [SUM_W-1:0] FIR_C_OUTER = -26'sd1;
  localparam logic signed [SUM_W-1:0] FIR_C_INNER = 26'sd9;
  localparam int FIR_SHIFT = 4;
  // DC remover pole: 1 - 2^-DC_K
  localparam int DC_K = 10;

  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_HB = 3'b001,
    SEQ_FIR = 3'b010,
    SEQ_DC = 3'b011,
    SEQ_WR = 3'b100
  } pmd_seq_type;

endpackage

// File: pmd_fifo_if.sv
`timescale 1ns/1ps
interface pmd_fifo_if #(
  parameter int W = 16,
  parameter int LW = 6
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [LW-1:0] level;

  modport ctrl (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, level
  );
  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, level
  );
endinterface

// File: pmd_fifo.sv
`timescale 1ns/1ps
module pmd_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Both sides of the buffer
  pmd_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("pmd_fifo: DEPTH must be a power of two of at least 2");
  if ($bits(port.level) < CW + 1)
    $error("pmd_fifo: level port too narrow");

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [W-1:0] dout_reg;
  logic dvalid_reg;

  wire push = port.in_valid && port.in_ready;
  wire load = (count_reg != '0) && (!dvalid_reg || port.out_ready);

  assign port.in_ready = (count_reg != CW'(DEPTH));
  assign port.out_valid = dvalid_reg;
  assign port.out_data = dout_reg;
  // Output register counts as one more entry
  assign port.level = $bits(port.level)'(count_reg) +
    $bits(port.level)'(dvalid_reg);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= port.in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (load)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + CW'(push) - CW'(load);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout_reg <= '0;
      dvalid_reg <= 1'b0;
    end
    else if (load)
    begin
      dout_reg <= mem[rd_ptr_reg];
      dvalid_reg <= 1'b1;
    end
    else if (port.out_ready)
      dvalid_reg <= 1'b0;
  end
endmodule

// File: pmd_decimator.sv
// Function
// - Each channel turns its one-bit density stream into signed 16-bit PCM.
// - Every microphone pair has one shared data input line.
// - One filter setting serves all channels; each channel has its own enable.
// - One microphone clock feeds all microphones, never gated per microphone.
// - Each channel runs CIC, half-band, FIR and DC removal, ratio selectable.
// - The filter chain aims at 80 dB stopband and under 0.2 dB ripple.
// - By default the passband spans 20 Hz to 22.5 kHz at 48 kHz output.
// - A time generator makes all stage strobes and the FIR/half-band starts.
// - Each channel's output goes to its own FIFO, read on its sample port.
// - Interrupt or DMA request rises when all enabled FIFOs pass watermark.
`timescale 1ns/1ps
module pmd_decimator
  import pmd_pkg::*;
#(
  parameter int PAIRS = 4,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [2*PAIRS-1:0] chan_enable,
  input wire logic [RATIO_W-1:0] decim_ratio,
  input wire logic [$clog2(DEPTH):0] watermark,
  input wire logic dma_select,
  // Microphone link
  output logic pdm_clk_out,
  input wire logic [PAIRS-1:0] pdm_data_in,
  // Channel sample ports
  output logic [2*PAIRS*PCM_W-1:0] channel_sample_port,
  output logic [2*PAIRS-1:0] sample_valid,
  input wire logic [2*PAIRS-1:0] sample_ready,
  // Requests and status
  output logic irq_req,
  output logic dma_req,
  output logic [2*PAIRS-1:0] overrun
);
  localparam int CH = 2 * PAIRS;
  localparam int LW = $clog2(DEPTH) + 2;

  if (PAIRS < 1)
    $error("pmd_decimator: PAIRS must be at least 1");
  if (DEPTH < 2)
    $error("pmd_decimator: DEPTH must be at least 2");

  function automatic logic [PCM_W-1:0] sat16(input logic signed [DC_W-1:0] v);
    logic signed [DC_W-1:0] hi;
    logic signed [DC_W-1:0] lo;
    hi = DC_W'(2 ** (PCM_W - 1) - 1);
    lo = -DC_W'(2 ** (PCM_W - 1));
    if (v > hi)
      sat16 = {1'b0, {(PCM_W-1){1'b1}}};
    else if (v < lo)
      sat16 = {1'b1, {(PCM_W-1){1'b0}}};
    else
      sat16 = v[PCM_W-1:0];
  endfunction

  // Reset release
  logic rst_meta_reg;
  logic rst_core_n;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_core_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_core_n <= rst_meta_reg;
    end
  end

  // Time generator: microphone clock phase
  wire clk_run = |chan_enable;
  logic [PH_W-1:0] ph_reg;
  wire [PH_W-1:0] ph_last = PH_W'(2 * PDM_HALF_CYCLES - 1);
  wire rise_cap = clk_run && (ph_reg == PH_W'(RISE_TAP));
  wire fall_cap = clk_run && (ph_reg == PH_W'(FALL_TAP));
  wire pdm_tick = fall_cap;

  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      ph_reg <= '0;
      pdm_clk_out <= 1'b0;
    end
    else
    begin
      // Clock stops only when no channel at all is enabled
      ph_reg <= (!clk_run || ph_reg == ph_last) ? '0 : ph_reg + 1'b1;
      pdm_clk_out <= clk_run &&
        (ph_reg < PH_W'(PDM_HALF_CYCLES) - 1'b1 || ph_reg == ph_last);
    end
  end

  // Data pins are asynchronous to sys_clk
  logic [PAIRS-1:0] data_meta_reg;
  logic [PAIRS-1:0] data_sync_reg;
  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      data_meta_reg <= '0;
      data_sync_reg <= '0;
    end
    else
    begin
      data_meta_reg <= pdm_data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  // Time generator: CIC decimation and stage sequencing
  logic [RATIO_W-1:0] dec_cnt_reg;
  wire [RATIO_W-1:0] ratio_eff = (decim_ratio < RATIO_W'(MIN_RATIO)) ?
    RATIO_W'(MIN_RATIO) : decim_ratio;
  wire cic_strobe = pdm_tick && (dec_cnt_reg >= ratio_eff - 1'b1);
  pmd_seq_type seq_reg;
  pmd_seq_type seq_next;
  logic hb_phase_reg;

  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
      dec_cnt_reg <= '0;
    else if (cic_strobe)
      dec_cnt_reg <= '0;
    else if (pdm_tick)
      dec_cnt_reg <= dec_cnt_reg + 1'b1;
  end

  always_comb
  begin
    case (seq_reg)
      SEQ_IDLE: seq_next = cic_strobe ? SEQ_HB : SEQ_IDLE;
      SEQ_HB: seq_next = hb_phase_reg ? SEQ_FIR : SEQ_IDLE;
      SEQ_FIR: seq_next = SEQ_DC;
      SEQ_DC: seq_next = SEQ_WR;
      SEQ_WR: seq_next = SEQ_IDLE;
      default: seq_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      seq_reg <= SEQ_IDLE;
      hb_phase_reg <= 1'b0;
    end
    else
    begin
      seq_reg <= seq_next;
      if (seq_reg == SEQ_HB)
        hb_phase_reg <= !hb_phase_reg;
    end
  end

  wire hb_go = (seq_reg == SEQ_HB);
  wire hb_take = hb_go && hb_phase_reg;
  wire fir_go = (seq_reg == SEQ_FIR);
  wire dc_go = (seq_reg == SEQ_DC);
  wire wr_go = (seq_reg == SEQ_WR);

  logic [CH-1:0] wm_ok;

  for (genvar c = 0; c < CH; c++)
  begin : g_ch
    // Even channel: rising edge microphone, odd: falling edge microphone
    wire cap = (c % 2 == 0) ? rise_cap : fall_cap;
    wire en = chan_enable[c];
    pmd_fifo_if #(.W(PCM_W), .LW(LW)) fif ();

    logic bit_reg;
    logic signed [CIC_W-1:0] integ_reg [3];
    logic signed [CIC_W-1:0] dly_reg [3];
    logic signed [CIC_W-1:0] cic_reg;
    wire signed [CIC_W-1:0] step = bit_reg ? CIC_W'(1) : {CIC_W{1'b1}};
    wire signed [CIC_W-1:0] comb0 = integ_reg[2] - dly_reg[0];
    wire signed [CIC_W-1:0] comb1 = comb0 - dly_reg[1];
    wire signed [CIC_W-1:0] comb2 = comb1 - dly_reg[2];

    // CIC: three integrators at bit rate, three combs at decimated rate
    // Filter state clears synchronously, so a disable needs no reset edge
    always_ff @(posedge sys_clk)
    begin
      if (!rst_core_n || !en)
      begin
        bit_reg <= 1'b0;
        integ_reg <= '{default: '0};
      end
      else
      begin
        if (cap)
          bit_reg <= data_sync_reg[c/2];
        if (pdm_tick)
        begin
          integ_reg[0] <= integ_reg[0] + step;
          integ_reg[1] <= integ_reg[1] + integ_reg[0];
          integ_reg[2] <= integ_reg[2] + integ_reg[1];
        end
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_core_n || !en)
      begin
        dly_reg <= '{default: '0};
        cic_reg <= '0;
      end
      else if (cic_strobe)
      begin
        dly_reg[0] <= integ_reg[2];
        dly_reg[1] <= comb0;
        dly_reg[2] <= comb1;
        cic_reg <= comb2;
      end
    end

    // Half-band, decimating by two
    logic signed [CIC_W-1:0] hb_tap_reg [6];
    logic signed [CIC_W-1:0] hb_reg;
    wire signed [SUM_W-1:0] hb_sum =
      (SUM_W'(cic_reg) + SUM_W'(hb_tap_reg[5])) * HB_C_OUTER +
      (SUM_W'(hb_tap_reg[1]) + SUM_W'(hb_tap_reg[3])) * HB_C_INNER +
      SUM_W'(hb_tap_reg[2]) * HB_C_MID;

    always_ff @(posedge sys_clk)
    begin
      if (!rst_core_n || !en)
      begin
        hb_tap_reg <= '{default: '0};
        hb_reg <= '0;
      end
      else if (hb_go)
      begin
        hb_tap_reg <= {cic_reg, hb_tap_reg[0:4]};
        if (hb_take)
          hb_reg <= CIC_W'(hb_sum >>> HB_SHIFT);
      end
    end

    // Compensating FIR
    logic signed [CIC_W-1:0] fir_tap_reg [3];
    logic signed [CIC_W-1:0] fir_reg;
    wire signed [SUM_W-1:0] fir_sum =
      (SUM_W'(hb_reg) + SUM_W'(fir_tap_reg[2])) * FIR_C_OUTER +
      (SUM_W'(fir_tap_reg[0]) + SUM_W'(fir_tap_reg[1])) * FIR_C_INNER;

    always_ff @(posedge sys_clk)
    begin
      if (!rst_core_n || !en)
      begin
        fir_tap_reg <= '{default: '0};
        fir_reg <= '0;
      end
      else if (fir_go)
      begin
        fir_tap_reg <= {hb_reg, fir_tap_reg[0:1]};
        fir_reg <= CIC_W'(fir_sum >>> FIR_SHIFT);
      end
    end

    // DC remover: subtract a slow running mean, corner far below 20 Hz
    logic signed [DC_W-1:0] dc_acc_reg;
    logic [PCM_W-1:0] pcm_reg;
    wire signed [DC_W-1:0] dc_y = DC_W'(fir_reg) - (dc_acc_reg >>> DC_K);

    always_ff @(posedge sys_clk)
    begin
      if (!rst_core_n || !en)
      begin
        dc_acc_reg <= '0;
        pcm_reg <= '0;
      end
      else if (dc_go)
      begin
        dc_acc_reg <= dc_acc_reg + dc_y;
        pcm_reg <= sat16(dc_y);
      end
    end

    // Full FIFO drops the new sample and flags it
    assign fif.in_valid = wr_go && en;
    assign fif.in_data = pcm_reg;
    assign fif.out_ready = sample_ready[c];
    assign channel_sample_port[c*PCM_W +: PCM_W] = fif.out_data;
    assign sample_valid[c] = fif.out_valid;
    assign wm_ok[c] = !en || (fif.level > LW'(watermark));

    always_ff @(posedge sys_clk or negedge rst_core_n)
    begin
      if (!rst_core_n)
        overrun[c] <= 1'b0;
      else
        overrun[c] <= fif.in_valid && !fif.in_ready;
    end

    pmd_fifo #(.W(PCM_W), .DEPTH(DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_core_n),
      .port(fif)
    );
  end

  // Requests need at least one enabled channel
  wire all_above = clk_run && (&wm_ok);

  always_ff @(posedge sys_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      irq_req <= 1'b0;
      dma_req <= 1'b0;
    end
    else
    begin
      irq_req <= all_above && !dma_select;
      dma_req <= all_above && dma_select;
    end
  end
endmodule

// File: pmd_decimator_properties.sv
`timescale 1ns/1ps
module pmd_decimator_checker
  import pmd_pkg::*;
#(
  parameter int PAIRS = 4,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [2*PAIRS-1:0] chan_enable,
  input wire logic [RATIO_W-1:0] decim_ratio,
  input wire logic [$clog2(DEPTH):0] watermark,
  input wire logic dma_select,
  // Microphone link
  input wire logic pdm_clk_out,
  input wire logic [PAIRS-1:0] pdm_data_in,
  // Channel sample ports
  input wire logic [2*PAIRS*PCM_W-1:0] channel_sample_port,
  input wire logic [2*PAIRS-1:0] sample_valid,
  input wire logic [2*PAIRS-1:0] sample_ready,
  // Requests and status
  input wire logic irq_req,
  input wire logic dma_req,
  input wire logic [2*PAIRS-1:0] overrun
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire any_on = |chan_enable;

  AST_RESET_QUIET:
    assert property ($rose(rst_n) |-> (!pdm_clk_out && !irq_req)[*2])
    else $error("output active after reset");
  // Shutting all channels off may stretch the low half or cut the high half short, hence the escapes
  AST_CLK_LOW_HALF:
    assert property (any_on && $fell(pdm_clk_out) |->
      (!pdm_clk_out)[*4] ##1 (pdm_clk_out || !any_on))
    else $error("clock low half not four cycles");
  AST_CLK_HIGH_HALF:
    assert property ($fell(pdm_clk_out) ##4 $rose(pdm_clk_out) |->
      (pdm_clk_out || !any_on)[*4] ##1 (!pdm_clk_out || !any_on))
    else $error("clock high half not four cycles");
  AST_CLK_PARKED:
    assert property ((!any_on)[*8] |-> !pdm_clk_out)
    else $error("clock runs with all channels off");
  AST_REQ_NONE_ON:
    assert property (!any_on |=> !irq_req && !dma_req)
    else $error("request with all channels off");
  AST_IRQ_ROUTE:
    assert property (irq_req |-> !$past(dma_select) && !dma_req)
    else $error("interrupt while dma selected");
  AST_DMA_ROUTE:
    assert property (dma_req |-> $past(dma_select))
    else $error("dma request while interrupt selected");
  for (genvar c = 0; c < 2*PAIRS; c++)
  begin : g_ch
    AST_WORD_HELD:
      assert property (sample_valid[c] && !sample_ready[c] |=>
        sample_valid[c] && $stable(channel_sample_port[c*PCM_W+:PCM_W]))
      else $error("waiting word changed");
    AST_DROP_FULL:
      assert property (overrun[c] |-> sample_valid[c] ##1 !overrun[c])
      else $error("overrun without full buffer");
  end
endmodule

bind pmd_decimator pmd_decimator_checker #(
  .PAIRS(PAIRS),
  .DEPTH(DEPTH)
) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .chan_enable(chan_enable),
  .decim_ratio(decim_ratio), .watermark(watermark),
  .dma_select(dma_select), .pdm_clk_out(pdm_clk_out),
  .pdm_data_in(pdm_data_in), .channel_sample_port(channel_sample_port),
  .sample_valid(sample_valid), .sample_ready(sample_ready),
  .irq_req(irq_req), .dma_req(dma_req), .overrun(overrun)
);

// File: pmd_mic_model.sv
`timescale 1ns/1ps
module pmd_mic_model #(
  parameter int PAIRS = 4
) (
  // Microphone link
  input wire logic pdm_clk,
  output logic [PAIRS-1:0] pdm_data,
  // Level each microphone sends
  input wire logic [2*PAIRS-1:0] mic_level
);
  logic [PAIRS-1:0] nxt;

  // Handover leaves garbage on the line before the new owner settles
  always @(pdm_clk)
  begin
    pdm_data = ~pdm_data;
    for (int p = 0; p < PAIRS; p++)
      nxt[p] = pdm_clk ? mic_level[2*p+1] : mic_level[2*p];
    #60;
    pdm_data = nxt;
  end
endmodule

// File: test_pmd_decimator.sv
`timescale 1ns/1ps
module test_pmd_decimator
  import pmd_pkg::*;
;
  localparam int CH = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [CH-1:0] chan_enable = 8'h00;
  logic [RATIO_W-1:0] decim_ratio = 7'h02;
  logic [5:0] watermark = 6'h00;
  logic dma_select = 1'b0;
  logic pdm_clk_out, irq_req, dma_req;
  logic [3:0] pdm_data_in;
  logic [CH*PCM_W-1:0] channel_sample_port;
  logic [CH-1:0] sample_valid, overrun;
  logic [CH-1:0] sample_ready = 8'hff;
  logic [CH-1:0] mic_level = 8'h00;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int eff_r = 2;
  int wm, k;
  int cnt[CH], sum[CH], last[CH], ovr[CH];
  bit rate_chk = 0;

  always #25 sys_clk = ~sys_clk;

  pmd_decimator u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .chan_enable(chan_enable),
    .decim_ratio(decim_ratio), .watermark(watermark),
    .dma_select(dma_select), .pdm_clk_out(pdm_clk_out),
    .pdm_data_in(pdm_data_in), .channel_sample_port(channel_sample_port),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .irq_req(irq_req), .dma_req(dma_req), .overrun(overrun)
  );
  pmd_mic_model u_mic (
    .pdm_clk(pdm_clk_out), .pdm_data(pdm_data_in), .mic_level(mic_level)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Model of the output side: pops, running sums and word spacing
  always @(posedge sys_clk)
  begin
    cyc++;
    for (int c = 0; c < CH; c++)
    begin
      if (sample_valid[c] === 1'b1 && sample_ready[c] === 1'b1)
      begin
        cnt[c]++;
        sum[c] += $signed(channel_sample_port[c*PCM_W+:PCM_W]);
        if (rate_chk && cnt[c] > 3)
          check(cyc - last[c], 16 * eff_r);
        last[c] = cyc;
      end
      if (overrun[c] === 1'b1)
        ovr[c]++;
    end
    if (cyc == 40000)
    begin
      failures++;
      print_verdict();
    end
  end

  initial
  begin
    void'($urandom(32'hf97d));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_cyc(3);
    // Ratio below the minimum, the maximum, then a random one
    for (int i = 0; i < 3; i++)
    begin
      chan_enable <= 8'h00;
      wait_cyc(100);
      eff_r = (i == 0) ? 2 : (i == 1) ? 64 : 2 + $urandom % 62;
      decim_ratio <= (i == 0) ? 7'h00 : eff_r[6:0];
      mic_level <= 8'($urandom);
      chan_enable <= (i == 0) ? 8'hff : 8'($urandom) | 8'h01;
      for (int c = 0; c < CH; c++)
      begin
        cnt[c] = 0;
        sum[c] = 0;
      end
      rate_chk = 1;
      wait_cyc(12 * 16 * eff_r);
      rate_chk = 0;
      for (int c = 0; c < CH; c++)
        if (chan_enable[c])
        begin
          check(sum[c] > 0, mic_level[c]);
          check(cnt[c] > 6, 1);
        end
        else
          check(cnt[c], 0);
    end
    // Stall channel 0 until its buffer overflows
    chan_enable <= 8'h00;
    wait_cyc(100);
    wm = 1 + $urandom % 20;
    watermark <= wm[5:0];
    decim_ratio <= 7'h02;
    sample_ready <= 8'hfe;
    chan_enable <= 8'h01;
    k = 0;
    while (sample_valid[0] !== 1'b1 && k < 2000)
    begin
      @(posedge sys_clk);
      k++;
    end
    check(sample_valid[0], 1);
    wait_cyc(wm * 32 - 8);
    check({irq_req, dma_req}, 0);
    wait_cyc(16);
    check({irq_req, dma_req}, 2);
    dma_select <= 1'b1;
    wait_cyc(3);
    check({irq_req, dma_req}, 1);
    wait_cyc(40 * 32);
    check(ovr[0] > 0, 1);
    chan_enable <= 8'h00;
    wait_cyc(3);
    check({irq_req, dma_req}, 0);
    wait_cyc(50);
    cnt[0] = 0;
    sample_ready <= 8'hff;
    wait_cyc(60);
    check(cnt[0], FIFO_DEPTH + 1);
    print_verdict();
  end
endmodule
